//--- ethernet_phy_control_two_bench.sv
// Self-checking bench for the second PHY control register block
`timescale 1ns/100ps
`default_nettype none
module ethernet_phy_control_two_bench;
  import pct_pkg::*;
  logic ref_clk, arst_n, reg_wr, reg_rd, strap_fx, link_up, speed_100, an_enable, activity;
  logic partner_forced_100, std_full_duplex, rx_idle, rx_sym_err, tx_clk_en, rx_clk_tick;
  logic ref_in_tick, go, tx_en_in, tx_er_in, tx_odd_nibble, fx_mode, pd_fast, full_duplex;
  logic tx_disable, led_link, mii_isolate, idle_err, tx_en_out, tx_er_out, pr, w, f;
  logic [4:0] reg_addr, a;
  logic [15:0] reg_wdata, reg_rdata, c1, c2, pe;
  logic [5:0] ln;
  logic [1:0] rmii_rxd_in, rmii_rxd, v;
  int miscompares, checked, ens, ers, i, k;
  pct_top dut_u (.ref_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .strap_fx, .link_up, .speed_100, .an_enable, .partner_forced_100, .std_full_duplex,
    .activity, .rx_idle, .rx_sym_err, .tx_en_in, .tx_er_in, .tx_clk_en, .tx_odd_nibble,
    .rx_clk_tick, .ref_in_tick, .rmii_rxd_in, .fx_mode, .pd_fast, .full_duplex, .tx_disable,
    .led_link, .mii_isolate, .idle_err, .tx_en_out, .tx_er_out, .rmii_rxd);
  pct_mac_model mac_u (.ref_clk, .arst_n, .tx_clk_en, .start(go), .tx_en_in, .tx_er_in,
    .tx_odd_nibble);
  task automatic cmp(input string nm, input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e)
    begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic results;
    if (miscompares == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One bus cycle: outputs checked mid-cycle, the model steps at the sampling edge
  task automatic bus(input logic wi, input logic r, input logic [4:0] ai, input logic [15:0] d);
    reg_wr <= wi;
    reg_rd <= r;
    reg_addr <= ai;
    reg_wdata <= d;
    @(negedge ref_clk);
    cmp("rdata", reg_rdata, pr ? pe : 16'h0000);
    cmp("fx_mode", fx_mode, c2[14]);
    cmp("pd_fast", pd_fast, c2[6]);
    @(posedge ref_clk);
    pr = r;
    pe = ai == PCT_CTL_ONE_ADDR ? c1 : ai == PCT_CTL_TWO_ADDR ? c2 : 16'h0000;
    // Speed-up bit is set one edge after a crossover mode appears, and it sticks
    if (wi && ai == PCT_CTL_TWO_ADDR) c2 = d;
    if (c1[6] | c1[5]) c2[6] = 1'b1;
    if (wi && ai == PCT_CTL_ONE_ADDR) c1 = d & PCT_CTL_ONE_MASK;
  endtask
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // TX clock at half the reference rate
  always @(posedge ref_clk) tx_clk_en <= !tx_clk_en;
  // Outputs counted mid-cycle on TX clock pulses, clear of the edges
  always @(negedge ref_clk)
    if (tx_clk_en)
    begin
      ens += tx_en_out;
      ers += tx_er_out;
    end
  initial
  begin
    {reg_wr, reg_rd, reg_addr, reg_wdata, link_up, speed_100, an_enable, activity} = '0;
    {partner_forced_100, std_full_duplex, rx_idle, rx_sym_err, tx_clk_en, go} = '0;
    {rx_clk_tick, ref_in_tick, rmii_rxd_in, pr, pe, c1, arst_n} = '0;
    strap_fx = 1'b1;
    c2 = 16'h4100;
    void'($urandom(32'hdfb9));
    repeat (10) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    bus(0, 1, PCT_CTL_TWO_ADDR, 0);
    bus(0, 1, PCT_CTL_ONE_ADDR, 0);
    // Random back-to-back traffic, unmapped places included
    repeat (300)
    begin
      k = $urandom % 3;
      a = k == 0 ? PCT_CTL_ONE_ADDR : k == 1 ? PCT_CTL_TWO_ADDR : 5'($urandom);
      w = 1'($urandom);
      bus(w, !w, a, 16'($urandom));
    end
    // Status outputs against random line conditions, fiber kept off
    repeat (80)
    begin
      bus(1, 0, PCT_CTL_TWO_ADDR, 16'($urandom) & 16'h803C);
      ln = 6'($urandom);
      {link_up, an_enable, partner_forced_100, std_full_duplex, rx_idle, rx_sym_err} <= ln;
      speed_100 <= 1'($urandom) | ln[3];
      activity <= c2[4] & 1'($urandom);
      bus(0, 0, 0, 0);
      @(negedge ref_clk);
      f = std_full_duplex | (c2[5] & partner_forced_100);
      cmp("full_duplex", full_duplex, f);
      cmp("tx_disable", tx_disable, c2[15] & speed_100 & !link_up);
      cmp("led", led_link, c2[4] ? link_up & speed_100 & f : link_up);
      cmp("isolate", mii_isolate, c2[3] & link_up & (!speed_100 | !f));
      cmp("idle_err", idle_err, c2[2] & rx_idle & rx_sym_err);
      @(posedge ref_clk);
    end
    // Odd-length frame with detection on, then off
    for (i = 0; i < 2; i++)
    begin
      bus(1, 0, PCT_CTL_TWO_ADDR, i ? 16'h0002 : 16'h0000);
      ens = 0;
      ers = 0;
      go <= 1'b1;
      bus(0, 0, 0, 0);
      go <= 1'b0;
      repeat (30) bus(0, 0, 0, 0);
      cmp("tx_en", 16'(ens), i ? 16'h0005 : 16'h0006);
      cmp("tx_er", 16'(ers), i ? 16'h0000 : 16'h0001);
    end
    // RMII data taken on the selected tick only; the other sees changed data
    for (i = 0; i < 2; i++)
    begin
      bus(1, 0, PCT_CTL_TWO_ADDR, 16'(i));
      v = 2'($urandom);
      rmii_rxd_in <= v;
      rx_clk_tick <= i;
      ref_in_tick <= !i;
      bus(0, 0, 0, 0);
      rmii_rxd_in <= ~v;
      rx_clk_tick <= !i;
      ref_in_tick <= i;
      bus(0, 0, 0, 0);
      {rx_clk_tick, ref_in_tick} <= 2'b00;
      repeat (3) bus(0, 0, 0, 0);
      cmp("rmii_rxd", rmii_rxd, v);
    end
    results();
  end
endmodule
`default_nettype wire

//--- pct_mac_model.sv
// Behavioural MAC sending one short odd-length frame
`timescale 1ns/100ps
`default_nettype none
module pct_mac_model (
  input wire logic ref_clk, // Clock
  input wire logic arst_n, // Reset, active low
  input wire logic tx_clk_en, // TX clock pulse
  input wire logic start, // Send a frame
  output logic tx_en_in, // Transmit enable
  output logic tx_er_in, // Transmit error, never raised
  output logic tx_odd_nibble // Frame ends on odd nibble
);
  int n;
  // Nibbles advance only on TX clock pulses, so the frame is five clocks
  always_ff @(posedge ref_clk or negedge arst_n)
    if (!arst_n) n <= 0;
    else if (start) n <= 5;
    else if (tx_clk_en && n > 0) n <= n - 1;
  assign tx_en_in = n > 0;
  assign tx_er_in = 1'b0;
  assign tx_odd_nibble = n > 0;
endmodule
`default_nettype wire

//--- pct_pkg.sv
// Package for the second PHY control register block
package pct_pkg;
  localparam int unsigned PCT_ADDR_W = 5;
  localparam int unsigned PCT_DATA_W = 16;
  localparam logic [4:0] PCT_CTL_ONE_ADDR = 5'h09;
  localparam logic [4:0] PCT_CTL_TWO_ADDR = 5'h0A;
  // Field positions of phy_control_two
  localparam int unsigned PCT_FAR_DROP_BIT = 15;
  localparam int unsigned PCT_FX_EN_BIT = 14;
  localparam int unsigned PCT_PD_FAST_BIT = 6;
  localparam int unsigned PCT_EXT_FD_BIT = 5;
  localparam int unsigned PCT_LED_ENH_BIT = 4;
  localparam int unsigned PCT_ISO_MII_BIT = 3;
  localparam int unsigned PCT_IDLE_ERR_BIT = 2;
  localparam int unsigned PCT_ODD_DIS_BIT = 1;
  localparam int unsigned PCT_RMII_CLK_BIT = 0;
  // Field positions of phy_control_one used here
  localparam int unsigned PCT_FAST_MDIX_BIT = 6;
  localparam int unsigned PCT_ROB_MDIX_BIT = 5;
  // Reset values; reserved 13:7 reset to 000_0010
  localparam logic [15:0] PCT_CTL_TWO_RST = 16'h0100;
  localparam logic [15:0] PCT_CTL_ONE_RST = 16'h0000;
  localparam logic [15:0] PCT_CTL_ONE_MASK = 16'hFFFE;
  localparam logic [15:0] PCT_UNMAPPED_RD = 16'h0000;
endpackage

//--- pct_sync2.sv
// Two-flop synchroniser for pin levels
`timescale 1ns/100ps
`default_nettype none
module pct_sync2 #(
  parameter int unsigned W = 1
) (
  input wire logic ref_clk, // Clock
  input wire logic arst_n, // Async reset, active low
  input wire logic [W-1:0] d, // Asynchronous level
  output logic [W-1:0] q // Synchronised level
);
  logic [W-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta <= '0;
      q <= '0;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

//--- pct_top.sv
// Second PHY control register and the behaviour its bits steer
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Far-end drop: TX off after 100M link loss
// - Fiber enable strapped at reset, writable later
// - Speed-up bit shortens parallel detect link-up
// - Speed-up forced set by fast/robust crossover
// - Extended duplex forces full against forced TX
// - Otherwise duplex follows standard resolution
// - Enhanced LED: lit only 100TX full duplex
// - Enhanced LED suppresses activity blinking
// - Isolate MII on 100 half or 10
// - Idle bit enables idle symbol error detection
// - Odd-nibble bit set disables odd detection
// - Odd nibble extends TX_EN one cycle, error
// - RMII clock bit set: sample on RX_CLK
// - Clear: sample on reference clock input
// - Robust crossover bit in first control register
module pct_top
  import pct_pkg::*;
(
  input wire logic ref_clk, // Reference clock, 200 MHz
  input wire logic arst_n, // Async reset, active low
  input wire logic [pct_pkg::PCT_ADDR_W-1:0] reg_addr, // Register address
  input wire logic [pct_pkg::PCT_DATA_W-1:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [pct_pkg::PCT_DATA_W-1:0] reg_rdata, // Read data, cycle after strobe
  input wire logic strap_fx, // Fiber strap pin
  input wire logic link_up, // Link established
  input wire logic speed_100, // Link at 100 Mbps
  input wire logic an_enable, // Auto-negotiation on
  input wire logic partner_forced_100, // Partner parallel-detected as forced 100TX
  input wire logic std_full_duplex, // Duplex from standard resolution
  input wire logic activity, // TX or RX activity
  input wire logic rx_idle, // Receiver in idle
  input wire logic rx_sym_err, // Invalid symbol seen
  input wire logic tx_en_in, // MAC transmit enable
  input wire logic tx_er_in, // MAC transmit error
  input wire logic tx_clk_en, // One-cycle pulse per TX clock
  input wire logic tx_odd_nibble, // Frame ends on odd nibble
  input wire logic rx_clk_tick, // Pulse on receive clock edge
  input wire logic ref_in_tick, // Pulse on reference input edge
  input wire logic [1:0] rmii_rxd_in, // RMII receive data source
  output logic fx_mode, // 100BASE-FX selected
  output logic pd_fast, // Shortened parallel detect link-up
  output logic full_duplex, // Resolved duplex
  output logic tx_disable, // Transmitter off
  output logic led_link, // Link LED, active high
  output logic mii_isolate, // MII outputs isolated
  output logic idle_err, // Idle symbol error pulse
  output logic tx_en_out, // Transmit enable after extension
  output logic tx_er_out, // Transmit error after extension
  output logic [1:0] rmii_rxd // Sampled RMII data
);
  import pct_pkg::*;

  // Strap capture sequence: two cycles settle the synchroniser, the third loads.
  // Loading earlier would take the synchroniser's reset value instead of the pin.
  typedef enum logic [3:0] {
    PCT_ST_SYNC1 = 4'b0001,
    PCT_ST_SYNC2 = 4'b0010,
    PCT_ST_LOAD = 4'b0100,
    PCT_ST_DONE = 4'b1000
  } pct_strap_e;

  logic [15:0] ctl_one;
  logic [15:0] ctl_two;
  logic strap_q;
  logic strap_open;
  pct_strap_e strap_st;
  pct_strap_e next_strap_st;
  logic tx_en_d;
  logic odd_d;
  logic odd_end;
  logic blink;
  logic [23:0] blink_cnt;
  logic [15:0] next_rdata;
  logic [15:0] next_ctl_one;
  logic [15:0] next_ctl_two;

  // Register index match, shared by the write and the read paths
  function automatic logic addr_hit(input logic [PCT_ADDR_W-1:0] a, input logic [4:0] idx);
    return a == idx;
  endfunction

  // Strap pin is asynchronous: synchronise before use
  pct_sync2 #(.W(1)) u_strap (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .d(strap_fx),
    .q(strap_q)
  );

  wire sel_one = addr_hit(reg_addr, PCT_CTL_ONE_ADDR);
  wire sel_two = addr_hit(reg_addr, PCT_CTL_TWO_ADDR);
  wire mdix_fast = ctl_one[PCT_FAST_MDIX_BIT] | ctl_one[PCT_ROB_MDIX_BIT];

  // Strap sequence advances one state per clock until the fiber bit is loaded
  always_comb
  begin
    next_strap_st = strap_st;
    case (strap_st)
      PCT_ST_SYNC1: next_strap_st = PCT_ST_SYNC2;
      PCT_ST_SYNC2: next_strap_st = PCT_ST_LOAD;
      PCT_ST_LOAD: next_strap_st = PCT_ST_DONE;
      PCT_ST_DONE: next_strap_st = PCT_ST_DONE;
      default: next_strap_st = PCT_ST_SYNC1;
    endcase
  end

  // Copy window stays open until the synchronised strap has been taken
  assign strap_open = (strap_st != PCT_ST_DONE);

  // Strap state register; software writes to the fiber bit win once it is done
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      strap_st <= PCT_ST_SYNC1;
    end
    else
    begin
      strap_st <= next_strap_st;
    end
  end

  // Write merge: crossover modes hold speed-up set
  always_comb
  begin
    next_ctl_two = ctl_two;
    if (reg_wr && sel_two)
    begin
      next_ctl_two = reg_wdata;
    end
    if (mdix_fast)
    begin
      next_ctl_two[PCT_PD_FAST_BIT] = 1'b1;
    end
    if (strap_open)
    begin
      next_ctl_two[PCT_FX_EN_BIT] = strap_q;
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    if (sel_two)
    begin
      next_rdata = ctl_two;
    end
    else if (sel_one)
    begin
      next_rdata = ctl_one;
    end
    else
    begin
      next_rdata = PCT_UNMAPPED_RD;
    end
  end

  // First control word: bit 0 stays clear, everything else is writable
  always_comb
  begin
    next_ctl_one = ctl_one;
    if (reg_wr && sel_one)
    begin
      next_ctl_one = reg_wdata & PCT_CTL_ONE_MASK;
    end
  end

  // First control word register
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctl_one <= PCT_CTL_ONE_RST;
    end
    else
    begin
      ctl_one <= next_ctl_one;
    end
  end

  // Second control word register; the strap sequence gates its fiber bit
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctl_two <= PCT_CTL_TWO_RST;
    end
    else
    begin
      ctl_two <= next_ctl_two;
    end
  end

  // Read data stand one cycle after the strobe and read zero otherwise
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reg_rdata <= 16'h0000;
    end
    else
    begin
      reg_rdata <= reg_rd ? next_rdata : 16'h0000;
    end
  end

  // Mode bits feed their consumers straight from the register
  assign fx_mode = ctl_two[PCT_FX_EN_BIT];
  assign pd_fast = ctl_two[PCT_PD_FAST_BIT];

  // Extended full duplex: local side negotiating or forced 100, partner forced 100TX
  wire ext_case = ctl_two[PCT_EXT_FD_BIT] & partner_forced_100 &
                  (an_enable | speed_100) & ~fx_mode;
  assign full_duplex = ext_case ? 1'b1 : std_full_duplex;

  // Far-end drop: TX held off while a 100M link is down, so the peer drops too.
  // Level based, so the transmitter comes back as soon as the link returns.
  assign tx_disable = ctl_two[PCT_FAR_DROP_BIT] & speed_100 & ~link_up;

  // LED blink divider, slow enough to be visible
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      blink_cnt <= 24'h000000;
      blink <= 1'b0;
    end
    else
    begin
      blink_cnt <= blink_cnt + 24'h000001;
      if (blink_cnt == 24'hFFFFFF)
      begin
        blink <= ~blink;
      end
    end
  end

  // Only a copper 100M full-duplex link qualifies for the enhanced LED
  wire tx_fd = link_up & speed_100 & full_duplex & ~fx_mode;
  wire led_enh = ctl_two[PCT_LED_ENH_BIT];
  // Enhanced mode shows link only, no activity blink
  assign led_link = led_enh ? tx_fd : (link_up & ~(activity & blink));

  // Isolation only on an established half-duplex 100 or any 10 link
  assign mii_isolate = ctl_two[PCT_ISO_MII_BIT] & link_up &
                       ((speed_100 & ~full_duplex) | ~speed_100);

  // Idle symbol errors reported only while the detection bit is set
  assign idle_err = ctl_two[PCT_IDLE_ERR_BIT] & rx_idle & rx_sym_err;

  // Odd-nibble extension: the TX clock after an odd frame ends is kept, with error
  wire odd_det = ~ctl_two[PCT_ODD_DIS_BIT] & tx_odd_nibble;
  assign odd_end = tx_en_d & odd_d & ~tx_en_in;

  // History of the previous TX clock, so the extension joins the frame with no gap
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_en_d <= 1'b0;
      odd_d <= 1'b0;
    end
    else if (tx_clk_en)
    begin
      tx_en_d <= tx_en_in;
      odd_d <= odd_det;
    end
  end

  // Transmit outputs advance on TX clock pulses only
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_en_out <= 1'b0;
      tx_er_out <= 1'b0;
    end
    else if (tx_clk_en)
    begin
      tx_en_out <= tx_en_in | odd_end;
      tx_er_out <= tx_er_in | odd_end;
    end
  end

  // RMII data capture on the chosen reference
  wire rmii_tick = ctl_two[PCT_RMII_CLK_BIT] ? rx_clk_tick : ref_in_tick;
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rmii_rxd <= 2'h0;
    end
    else if (rmii_tick)
    begin
      rmii_rxd <= rmii_rxd_in;
    end
  end
endmodule
`default_nettype wire

//--- pct_top_assertions.sv
// Checker for the second PHY control register block
`timescale 1ns/100ps
`default_nettype none
module pct_top_chk
  import pct_pkg::*;
(
  input wire logic ref_clk, // Clock
  input wire logic arst_n, // Reset, active low
  input wire logic [pct_pkg::PCT_ADDR_W-1:0] reg_addr, // Address
  input wire logic [pct_pkg::PCT_DATA_W-1:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [pct_pkg::PCT_DATA_W-1:0] reg_rdata, // Read data
  input wire logic link_up, // Link up
  input wire logic speed_100, // 100 Mbps
  input wire logic std_full_duplex, // Standard duplex
  input wire logic rx_idle, // Receiver idle
  input wire logic rx_sym_err, // Bad symbol
  input wire logic fx_mode, // Fiber mode
  input wire logic pd_fast, // Fast parallel detect
  input wire logic full_duplex, // Resolved duplex
  input wire logic tx_disable, // Transmitter off
  input wire logic led_link, // Link LED
  input wire logic mii_isolate, // MII isolated
  input wire logic idle_err // Idle error
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // Register accesses to the second control word
  sequence s_rd2; reg_rd && reg_addr == PCT_CTL_TWO_ADDR; endsequence
  sequence s_wr2; reg_wr && reg_addr == PCT_CTL_TWO_ADDR; endsequence
  wire unmap = reg_addr != PCT_CTL_ONE_ADDR && reg_addr != PCT_CTL_TWO_ADDR;
  a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not idle");
  a_unmapped_zero: assert property (reg_rd && unmap |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_fx_write: assert property (s_wr2 |=> fx_mode == $past(reg_wdata[14]))
    else $error("fiber bit not written");
  a_fx_read: assert property (s_rd2 |=> reg_rdata[14] == $past(fx_mode))
    else $error("fiber bit readback");
  a_pd_read: assert property (s_rd2 |=> reg_rdata[6] == $past(pd_fast))
    else $error("speed-up bit readback");
  a_txdis_cause: assert property (tx_disable |-> speed_100 && !link_up)
    else $error("transmitter off without cause");
  a_duplex_std: assert property (std_full_duplex |-> full_duplex)
    else $error("full duplex lost");
  a_led_link: assert property (led_link |-> link_up)
    else $error("LED lit without link");
  a_iso_cause: assert property (mii_isolate |-> link_up && !(speed_100 && full_duplex))
    else $error("isolation on wrong link");
  a_idle_err: assert property (idle_err |-> rx_idle && rx_sym_err)
    else $error("idle error without cause");
endmodule
bind pct_top pct_top_chk chk_u (.ref_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .link_up, .speed_100, .std_full_duplex, .rx_idle, .rx_sym_err, .fx_mode,
  .pd_fast, .full_duplex, .tx_disable, .led_link, .mii_isolate, .idle_err);
`default_nettype wire
